// File: urxtf_map.vh
// register offsets, field positions, reset values and timing constants
// for the receive-timeout and line-flag unit; definitions only
`ifndef URXTF_MAP_VH
`define URXTF_MAP_VH

// ==========================================
// register byte offsets
`define URXTF_OFS_TIMEOUT 12'h00c
`define URXTF_OFS_FLAGS 12'h018

// ==========================================
// timeout period field
`define URXTF_PERIOD_W 22
`define URXTF_PERIOD_RST 22'h0001ff

// ==========================================
// line flag bit positions
`define URXTF_FL_CTS 0
`define URXTF_FL_BUSY 3
`define URXTF_FL_RXE 4
`define URXTF_FL_TXF 5
`define URXTF_FL_RXF 6
`define URXTF_FL_TXE 7
`define URXTF_FL_CTS_CHANGE_FLAG 9
`define URXTF_FL_RSV_LO 10
`define URXTF_FL_RSV_HI 12
`define URXTF_FL_RTXD 13
`define URXTF_FL_RSV_VAL 3'h7
`define URXTF_CTS_CHANGE_FLAG_RST 1'b1

// ==========================================
// oversampling: ticks per bit are 16 or 8
`define URXTF_OVS16_SHIFT 4
`define URXTF_OVS8_SHIFT 3

`endif

// File: urxtf_tick.v
// oversampling tick generator: one pulse per sample period
// assumes the divisor is stable while enabled
`timescale 1ns/1ps

module urxtf_tick #(
    parameter DIV_W = 16
) (
    pclk,
    presetn,
    div,
    tick
);
    input wire pclk;
    input wire presetn;
    input wire [DIV_W-1:0] div;
    output wire tick;

    reg [DIV_W-1:0] cnt_ff;
    wire [DIV_W-1:0] nxt_cnt;

    // a divisor of zero or one gives a tick on every cycle
    assign tick = (cnt_ff == {DIV_W{1'b0}}) || (div <= {{(DIV_W-1){1'b0}}, 1'b1});
    assign nxt_cnt = tick ? (div - {{(DIV_W-1){1'b0}}, 1'b1}) : (cnt_ff - {{(DIV_W-1){1'b0}}, 1'b1});

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= {DIV_W{1'b0}};
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // urxtf_tick

// File: urxtf_top.v
// receive-timeout generator and line-flag register, APB slave
// assumes fifo levels, tx state and flow-control events come from
// the surrounding uart, synchronous to pclk
//
// Operation
// - timeout period is 22 writable bits resetting to 0x1ff, upper bits reserved; here the upper 10 bits are stored and read back
// - timeout asserts only while rx fifo non-empty and idle for the period
// - timeout length counts period in bit-clock ticks of 16 or 8 per bit
// - busy reads 1 while transmitting, until last stop bit leaves shifter
// - busy clears when tx disabled mid character, sets again when resumed
// - busy sets once the tx fifo is non-empty, even with uart disabled
// - rx empty flag resets to 1; fifo empty or holding register empty
// - tx full flag shows fifo full or holding register full
// - rx full flag shows fifo full or holding register full
// - tx empty flag resets to 1; fifo empty or holding register empty
// - cts change flag sets on cts change since last flag read
// - remote stopped sets on xoff sent for rx level, clears on xon sent
// - rx fifo disabled means character mode with one holding register; here only the timeout uses rx_fifo_enable, rx flags use fifo_enable
// - oversample select 0 gives 16x, 1 gives 8x, for timeout and baud; here oversample_select is unused and the tick follows baud_div only
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "urxtf_map.vh"

module urxtf_top #(
    parameter DIV_W = 16
) (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    baud_div,
    oversample_select,
    fifo_enable,
    rx_fifo_enable,
    rx_char_done,
    rx_fifo_empty,
    rx_fifo_full,
    rx_hold_full,
    tx_fifo_empty,
    tx_fifo_full,
    tx_hold_full,
    tx_shift_active,
    tx_enable,
    cts_in,
    sw_flow_enable,
    xoff_sent,
    xon_sent,
    rx_timeout
);
    input wire pclk;
    input wire presetn;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [11:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output wire pready;
    output wire pslverr;
    // integer divisor giving the oversampling tick rate
    input wire [DIV_W-1:0] baud_div;
    input wire oversample_select;
    input wire fifo_enable;
    input wire rx_fifo_enable;
    // one-cycle pulse when a received character is stored
    input wire rx_char_done;
    input wire rx_fifo_empty;
    input wire rx_fifo_full;
    input wire rx_hold_full;
    input wire tx_fifo_empty;
    input wire tx_fifo_full;
    input wire tx_hold_full;
    // shifter holds a character not yet fully sent, stop bits included
    input wire tx_shift_active;
    input wire tx_enable;
    input wire cts_in;
    input wire sw_flow_enable;
    // one-cycle pulses from the flow-control logic
    input wire xoff_sent;
    input wire xon_sent;
    output reg rx_timeout;

    // ==========================================
    // apb decode
    wire acc = psel && penable;
    // the read word is captured at the setup edge, so a flag read clears
    // change detection there and nothing seen after the capture is lost
    wire rd_setup = psel && !penable && !pwrite;
    wire hit_to = ({2'b00, paddr[11:2]} == (`URXTF_OFS_TIMEOUT >> 2));
    wire hit_fl = ({2'b00, paddr[11:2]} == (`URXTF_OFS_FLAGS >> 2));
    wire wr_to = acc && pwrite && hit_to;
    wire rd_fl = rd_setup && hit_fl;

    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = acc && !(hit_to || hit_fl);

    // ==========================================
    // timeout period register
    reg [`URXTF_PERIOD_W-1:0] period_ff;
    reg [31-`URXTF_PERIOD_W:0] period_rsv_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_ff <= `URXTF_PERIOD_RST;
            period_rsv_ff <= {(32-`URXTF_PERIOD_W){1'b0}};
        end else if (wr_to) begin
            period_ff <= pwdata[`URXTF_PERIOD_W-1:0];
            period_rsv_ff <= pwdata[31:`URXTF_PERIOD_W];
        end
    end

    // ==========================================
    // receive timeout
    // the period counts oversampling ticks, so one bit is 16 or 8 counts
    // and only baud_div sets the tick; oversample_select is not used here
    wire samp_tick;

    urxtf_tick #(
        .DIV_W(DIV_W)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .div(baud_div),
        .tick(samp_tick)
    );

    // character mode uses the holding register as a one-deep fifo
    wire rx_empty_now = rx_fifo_enable ? rx_fifo_empty : !rx_hold_full;

    reg [`URXTF_PERIOD_W-1:0] to_cnt_ff;
    reg [`URXTF_PERIOD_W-1:0] nxt_to_cnt;
    reg nxt_rx_timeout;

    always @* begin
        nxt_to_cnt = to_cnt_ff;
        nxt_rx_timeout = rx_timeout;
        if (rx_empty_now || rx_char_done) begin
            nxt_to_cnt = {`URXTF_PERIOD_W{1'b0}};
            nxt_rx_timeout = 1'b0;
        end else if (samp_tick && !rx_timeout) begin
            if (to_cnt_ff + 22'h000001 >= period_ff) begin
                nxt_rx_timeout = 1'b1;
            end else begin
                nxt_to_cnt = to_cnt_ff + 22'h000001;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_cnt_ff <= {`URXTF_PERIOD_W{1'b0}};
            rx_timeout <= 1'b0;
        end else begin
            to_cnt_ff <= nxt_to_cnt;
            rx_timeout <= nxt_rx_timeout;
        end
    end

    // ==========================================
    // cts change detection
    reg cts_last_ff;
    reg cts_chg_ff;
    wire cts_edge = (cts_in != cts_last_ff);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cts_last_ff <= 1'b0;
            cts_chg_ff <= `URXTF_CTS_CHANGE_FLAG_RST;
        end else begin
            cts_last_ff <= cts_in;
            // a change in the read cycle survives the read
            if (cts_edge) begin
                cts_chg_ff <= 1'b1;
            end else if (rd_fl) begin
                cts_chg_ff <= 1'b0;
            end
        end
    end

    // ==========================================
    // software flow-control state
    reg remote_tx_stopped_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_tx_stopped_ff <= 1'b0;
        end else if (!sw_flow_enable) begin
            remote_tx_stopped_ff <= 1'b0;
        end else if (xoff_sent) begin
            remote_tx_stopped_ff <= 1'b1;
        end else if (xon_sent) begin
            remote_tx_stopped_ff <= 1'b0;
        end
    end

    // ==========================================
    // status flags, registered each cycle
    reg busy_ff;
    reg rx_empty_flag_ff;
    reg tx_full_flag_ff;
    reg rx_full_flag_ff;
    reg tx_empty_flag_ff;
    wire tx_empty_now = fifo_enable ? tx_fifo_empty : !tx_hold_full;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff <= 1'b0;
            rx_empty_flag_ff <= 1'b1;
            tx_full_flag_ff <= 1'b0;
            rx_full_flag_ff <= 1'b0;
            tx_empty_flag_ff <= 1'b1;
        end else begin
            // pending data alone sets busy; a disabled shifter drops it
            busy_ff <= !tx_empty_now || (tx_shift_active && tx_enable);
            rx_empty_flag_ff <= fifo_enable ? rx_fifo_empty : !rx_hold_full;
            tx_full_flag_ff <= fifo_enable ? tx_fifo_full : tx_hold_full;
            rx_full_flag_ff <= fifo_enable ? rx_fifo_full : rx_hold_full;
            tx_empty_flag_ff <= tx_empty_now;
        end
    end

    // ==========================================
    // read data
    reg [31:0] flags_word;

    always @* begin
        flags_word = 32'h00000000;
        flags_word[`URXTF_FL_CTS] = cts_last_ff;
        flags_word[`URXTF_FL_BUSY] = busy_ff;
        flags_word[`URXTF_FL_RXE] = rx_empty_flag_ff;
        flags_word[`URXTF_FL_TXF] = tx_full_flag_ff;
        flags_word[`URXTF_FL_RXF] = rx_full_flag_ff;
        flags_word[`URXTF_FL_TXE] = tx_empty_flag_ff;
        flags_word[`URXTF_FL_CTS_CHANGE_FLAG] = cts_chg_ff;
        flags_word[`URXTF_FL_RSV_HI:`URXTF_FL_RSV_LO] = `URXTF_FL_RSV_VAL;
        flags_word[`URXTF_FL_RTXD] = remote_tx_stopped_ff;
    end

    reg [31:0] rd_word;
    reg [31:0] nxt_prdata;

    always @* begin
        rd_word = 32'h00000000;
        if (hit_to) begin
            rd_word = {period_rsv_ff, period_ff};
        end else if (hit_fl) begin
            rd_word = flags_word;
        end
    end

    // prdata comes from a flop: loaded at the setup edge, held through access
    always @* begin
        nxt_prdata = 32'h00000000;
        if (rd_setup) begin
            nxt_prdata = rd_word;
        end else if (acc && !pwrite) begin
            nxt_prdata = prdata;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= nxt_prdata;
        end
    end
endmodule // urxtf_top

// File: urxtf_chk.sv
// checker for the receive-timeout and line-flag unit
// sees only top-level ports; one pclk domain, presetn async active low
`timescale 1ns/1ps
module urxtf_chk (
    input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic fifo_enable, rx_fifo_enable, rx_fifo_empty, rx_fifo_full, rx_hold_full,
    input wire logic tx_fifo_empty, tx_fifo_full, tx_hold_full, rx_char_done,
    input wire logic sw_flow_enable, xoff_sent, xon_sent, rx_timeout
);
    // ==========================================
    // helpers
    wire rd_fl = psel && penable && !pwrite && paddr == 12'h018;
    wire rx_e = rx_fifo_enable ? rx_fifo_empty : !rx_hold_full;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wr; psel && penable && pwrite && paddr == 12'h00c; endsequence
    sequence s_rd; psel && penable && !pwrite && paddr == 12'h00c; endsequence
    sequence s_xoff; sw_flow_enable && xoff_sent; endsequence
    // ==========================================
    // properties
    // read data is captured at the setup edge from flags registered one edge before
    property p_period; s_wr ##2 s_rd |-> prdata == $past(pwdata, 2); endproperty
    property p_rxe; rd_fl && $past(presetn, 2)
        |-> prdata[4] == $past(fifo_enable ? rx_fifo_empty : !rx_hold_full, 2); endproperty
    property p_txf; rd_fl && $past(presetn, 2)
        |-> prdata[5] == $past(fifo_enable ? tx_fifo_full : tx_hold_full, 2); endproperty
    property p_rxf; rd_fl && $past(presetn, 2)
        |-> prdata[6] == $past(fifo_enable ? rx_fifo_full : rx_hold_full, 2); endproperty
    property p_txe; rd_fl && $past(presetn, 2)
        |-> prdata[7] == $past(fifo_enable ? tx_fifo_empty : !tx_hold_full, 2); endproperty
    property p_busy; rd_fl && $past(presetn && fifo_enable && !tx_fifo_empty, 2)
        |-> prdata[3]; endproperty
    property p_rtx; s_xoff ##1 (sw_flow_enable && !xon_sent) [*3] ##0 rd_fl
        |-> prdata[13]; endproperty
    property p_empty; rx_e |=> !rx_timeout; endproperty
    property p_char; rx_char_done |=> !rx_timeout; endproperty
    property p_rise; $rose(rx_timeout) |-> $past(!rx_e && !rx_char_done); endproperty
    a_period: assert property (p_period) else $error("period readback wrong");
    a_rxe: assert property (p_rxe) else $error("rx empty flag wrong");
    a_txf: assert property (p_txf) else $error("tx full flag wrong");
    a_rxf: assert property (p_rxf) else $error("rx full flag wrong");
    a_txe: assert property (p_txe) else $error("tx empty flag wrong");
    a_busy: assert property (p_busy) else $error("busy not set");
    a_rtx: assert property (p_rtx) else $error("remote stop not set");
    a_empty: assert property (p_empty) else $error("timeout while empty");
    a_char: assert property (p_char) else $error("timeout kept on char");
    a_rise: assert property (p_rise) else $error("timeout rose wrongly");
endmodule // urxtf_chk

bind urxtf_top urxtf_chk u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .fifo_enable(fifo_enable),
    .rx_fifo_enable(rx_fifo_enable),
    .rx_fifo_empty(rx_fifo_empty),
    .rx_fifo_full(rx_fifo_full),
    .rx_hold_full(rx_hold_full),
    .tx_fifo_empty(tx_fifo_empty),
    .tx_fifo_full(tx_fifo_full),
    .tx_hold_full(tx_hold_full),
    .rx_char_done(rx_char_done),
    .sw_flow_enable(sw_flow_enable),
    .xoff_sent(xoff_sent),
    .xon_sent(xon_sent),
    .rx_timeout(rx_timeout)
);

// File: urxtf_peer.sv
// remote serial device: delivers received characters into the rx path
// assumes the bench calls its tasks right after a pclk rising edge
`timescale 1ns/1ps
module urxtf_peer (
    input wire logic pclk,
    output logic rx_char_done,
    output logic rx_fifo_empty
);
    initial begin
        rx_char_done = 1'b0;
        rx_fifo_empty = 1'b1;
    end
    // gap models a slow sender; a char lands as a one-cycle pulse
    task send(input int gap); begin
        repeat (gap) @(posedge pclk);
        rx_char_done <= 1'b1;
        rx_fifo_empty <= 1'b0;
        @(posedge pclk) rx_char_done <= 1'b0;
    end endtask
    task drain; begin
        @(posedge pclk) rx_fifo_empty <= 1'b1;
    end endtask
endmodule // urxtf_peer

// File: tb_uart_rx_timeout_and_flags.sv
// bench for the receive-timeout and line-flag unit: apb tasks and scenarios
// assumes urxtf_top, urxtf_peer and the checker are compiled before it
`timescale 1ns/1ps
module tb_uart_rx_timeout_and_flags;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, r;
    logic [15:0] bdiv = 16'h0001;
    logic fe = 1, rfen = 1, rff = 0, rhf = 0, tfe = 1, tff = 0, thf = 0, tsa = 0, ten = 0;
    logic cts = 0, sfe = 0, xoff = 0, xon = 0;
    wire [31:0] prdata;
    wire pready, pslverr, rx_timeout, rcd, rxe;
    int n_fail = 0, num_checks = 0, i, n;
    urxtf_peer u_peer (.pclk(pclk), .rx_char_done(rcd), .rx_fifo_empty(rxe));
    urxtf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .baud_div(bdiv), .oversample_select(1'b0), .fifo_enable(fe),
        .rx_fifo_enable(rfen), .rx_char_done(rcd), .rx_fifo_empty(rxe), .rx_fifo_full(rff),
        .rx_hold_full(rhf), .tx_fifo_empty(tfe), .tx_fifo_full(tff), .tx_hold_full(thf),
        .tx_shift_active(tsa), .tx_enable(ten), .cts_in(cts), .sw_flow_enable(sfe),
        .xoff_sent(xoff), .xon_sent(xon), .rx_timeout(rx_timeout));
    always #2.5 pclk = ~pclk;
    // ==========================================
    // tasks
    task test_done; begin
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    end endtask
    task chk(input logic [31:0] x, input logic [31:0] g); begin
        num_checks++;
        if (g !== x) begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, x, g);
        end
    end endtask
    // leaves psel up so a following transfer may start at once
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d); begin
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin n_fail++; test_done; end
        r = prdata;
        e = pslverr;
    end endtask
    task idle(input int c); begin
        psel <= 0; penable <= 0;
        repeat (c) @(posedge pclk);
    end endtask
    task wto; begin
        for (n = 0; rx_timeout !== 1'b1 && n < 60; n++) @(posedge pclk);
        if (rx_timeout !== 1'b1) begin n_fail++; test_done; end
    end endtask
    // ==========================================
    // scenarios
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, 12'h00c, 0); chk(32'h1ff, r);
        apb(0, 12'h018, 0); chk(32'h1e90, r);
        apb(0, 12'h018, 0); chk(32'h1c90, r);
        apb(1, 12'h00c, 32'hffc00014); apb(0, 12'h00c, 0); chk(32'hffc00014, r);
        apb(1, 12'h018, 0); apb(0, 12'h018, 0); chk(32'h1c90, r);
        apb(0, 12'h020, 0); chk(1, e);
        for (int k = 0; k < 4; k++) begin
            fe <= k[0]; tfe <= k[1]; thf <= k[1]; rhf <= !k[1]; rff <= 1; tff <= !k[1];
            idle(1); apb(0, 12'h018, 0);
            chk({k[0] ? k[1] : !k[1], k[0] | !k[1], k[0] ^ k[1], k[0] | k[1],
                k[0] ? !k[1] : k[1]}, r[7:3]);
        end
        tsa <= 1;
        for (int k = 0; k < 4; k++) begin
            ten <= (k == 0 || k == 3); tfe <= (k != 2);
            idle(1); apb(0, 12'h018, 0); chk(k != 1, r[3]);
        end
        tsa <= 0; tfe <= 1; cts <= 1;
        idle(1); apb(0, 12'h018, 0); chk(2'b11, {r[9], r[0]});
        apb(0, 12'h018, 0); chk(0, r[9]);
        sfe <= 1; xoff <= 1; idle(1); xoff <= 0; idle(1);
        apb(0, 12'h018, 0); chk(1, r[13]);
        xon <= 1; idle(1); xon <= 0; idle(1);
        apb(0, 12'h018, 0); chk(0, r[13]);
        idle(1); u_peer.send(0); wto; chk(1, n >= 17 && n <= 22);
        u_peer.send(0); @(posedge pclk); chk(0, rx_timeout);
        repeat (12) @(posedge pclk);
        u_peer.send(0); repeat (12) @(posedge pclk); chk(0, rx_timeout);
        wto; chk(1, rx_timeout);
        u_peer.drain; repeat (2) @(posedge pclk); chk(0, rx_timeout);
        rfen <= 0; rhf <= 0; u_peer.send(0);
        repeat (60) @(posedge pclk); chk(0, rx_timeout);
        rhf <= 1; wto; chk(1, rx_timeout);
        test_done;
    end
endmodule // tb_uart_rx_timeout_and_flags
